// File: sim/sbi_bus_if_chk.sv
// Purpose: Port assertions for the system bus pin interface.
// Assumes: Bound to sbi_bus_if; core and link clock domains.
// Notes:   Reset-output pacing is counted on the link clock.
`timescale 1ns/10ps
module sbi_bus_if_chk (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               clk_link,
    input wire logic               reset_out_n,
    input wire logic               bus_clock_out,
    input wire sbi_pkg::sbi_boot_t boot_cfg,
    input wire logic               req_ready,
    input wire logic               ext_owner,
    input wire logic               addr_strobe_n_out,
    input wire logic [7:0]         chip_select_n,
    input wire logic               read_enable_n,
    input wire logic [3:0]         write_enable_n,
    input wire logic               read_not_write_out,
    input wire logic               read_not_write_oe,
    input wire logic               data_ack_n_oe,
    input wire logic               bus_grant_n
);
    logic [3:0] n_bclk;
    logic       bclk_q;
    // Bus clock rises seen while reset output is low, saturating
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            n_bclk <= 4'h0;
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= bus_clock_out;
            if (reset_out_n)
                n_bclk <= 4'h0;
            else if (bus_clock_out && !bclk_q && n_bclk != 4'hF)
                n_bclk <= n_bclk + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_rst_pacing: assert property (@(posedge clk_link) disable iff (!rst_n)
        $rose(reset_out_n) |-> n_bclk >= 4'h8) else $error("reset out rose early");
    chk_read_dir: assert property (@(posedge clk) disable iff (!rst_n)
        !read_enable_n |-> read_not_write_out && read_not_write_oe) else $error("bad read dir");
    chk_write_dir: assert property (@(posedge clk) disable iff (!rst_n)
        write_enable_n != 4'hF |-> !read_not_write_out && read_enable_n)
        else $error("bad write dir");
    chk_strobe_cs: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(addr_strobe_n_out) |-> chip_select_n != 8'hFF ##1 addr_strobe_n_out)
        else $error("strobe without select");
    chk_cs_single: assert property (@(posedge clk) disable iff (!rst_n)
        chip_select_n != 8'hFF |-> $onehot(~chip_select_n)) else $error("many selects");
    chk_grant_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_grant_n |-> !req_ready && chip_select_n == 8'hFF) else $error("busy granted");
    chk_ack_owner: assert property (@(posedge clk) disable iff (!rst_n)
        data_ack_n_oe |-> ext_owner) else $error("ack driven unowned");
    chk_boot_hold: assert property (@(posedge clk) disable iff (!rst_n)
        reset_out_n && $past(reset_out_n) |-> $stable(boot_cfg)) else $error("boot moved");
endmodule

bind sbi_bus_if sbi_bus_if_chk u_sbi_bus_if_chk (.clk, .rst_n, .clk_link, .reset_out_n,
    .bus_clock_out, .boot_cfg, .req_ready, .ext_owner, .addr_strobe_n_out, .chip_select_n,
    .read_enable_n, .write_enable_n, .read_not_write_out, .read_not_write_oe,
    .data_ack_n_oe, .bus_grant_n);

// File: sim/sbi_mem_model.sv
// Purpose: Memory slave behind the chip selects.
// Assumes: Sixteen words picked by address bits 5:2.
// Notes:   Released data lines show the inverse of the last word.
`timescale 1ns/10ps
module sbi_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  wait_cyc,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic [31:0]      rdata,
    input  wire logic [7:0]  cs_n,
    input  wire logic        re_n,
    input  wire logic [3:0]  we_n,
    output logic             ack_n
);
    logic [31:0] mem [16];
    logic [31:0] last;
    logic [1:0]  cnt;
    wire         sel = cs_n != 8'hFF && (!re_n || we_n != 4'hF);
    wire  [3:0]  idx = addr[5:2];
    assign rdata = (sel && !re_n) ? mem[idx] : ~last;
    initial for (int i = 0; i < 16; i++) mem[i] = 32'hA5A5_0000 + 32'(i);
    // Acknowledge after wait_cyc cycles, so the slave can be prompt or slow
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt   <= 2'h0;
            ack_n <= 1'b1;
            last  <= 32'h0;
        end else begin
            // Count up to the wait, then hold the acknowledge until deselected
            cnt   <= !sel ? 2'h0 : (cnt == wait_cyc) ? cnt : cnt + 2'h1;
            ack_n <= !(sel && cnt == wait_cyc);
            if (sel && !re_n)
                last <= mem[idx];
            for (int b = 0; b < 4; b++)
                if (sel && !we_n[b])
                    mem[idx][8*b +: 8] <= wdata[8*b +: 8];
        end
    end
endmodule

// File: sim/test_sbi_bus_if.sv
// Purpose: Self-checking bench for the system bus pin interface.
// Assumes: Memory model behind the selects; bench plays the external master.
// Notes:   Released address, size and direction lines read back inverted.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
`define WAIT(c) begin for (int n = 0; n < 400 && !(c); n++) @(negedge clk); \
    if (!(c)) n_errors++; end
module test_sbi_bus_if;
    logic        clk = 1'b0, clk_link = 1'b0, rst_n = 1'b0, reset_in_n = 1'b1;
    logic        boot_width_strap = 1'b1, boot_device_strap = 1'b0, req_valid = 1'b0;
    logic        ext_ack_req = 1'b0, bus_request_n = 1'b1;
    logic [1:0]  wait_cyc = 2'h0;
    sbi_pkg::sbi_req_t  req = '0;
    sbi_pkg::sbi_boot_t boot_cfg;
    logic        reset_out_n, bus_clock_out, req_ready, rsp_valid, ext_owner, m_ack_n;
    logic        addr_strobe_n_in, addr_strobe_n_out, addr_strobe_n_oe, read_enable_n;
    logic        read_not_write_in, read_not_write_out, read_not_write_oe, bus_grant_n;
    logic        data_ack_n_in, data_ack_n_out, data_ack_n_oe, s_rnw;
    logic        sys_addr_bus_oe, sys_data_bus_oe, xfer_size_code_oe;
    logic [1:0]  xfer_size_code_in, xfer_size_code_out, s_size;
    logic [3:0]  write_enable_n, s_we, s_oe;
    logic [7:0]  chip_select_n, s_cs;
    logic [31:0] rsp_rdata, sys_addr_bus_in, sys_addr_bus_out, sys_data_bus_in, q;
    logic [31:0] sys_data_bus_out, m_rdata, s_addr;
    int          n_errors = 0, cmp_count = 0, cyc = 0, b;
    initial forever #5 clk = ~clk;
    initial begin
        #1.3;
        forever #3 clk_link = ~clk_link;
    end
    assign sys_addr_bus_in   = sys_addr_bus_oe ? sys_addr_bus_out : ~sys_addr_bus_out;
    assign sys_data_bus_in   = sys_data_bus_oe ? sys_data_bus_out : m_rdata;
    assign addr_strobe_n_in  = addr_strobe_n_oe ? addr_strobe_n_out : 1'b1;
    assign xfer_size_code_in = xfer_size_code_oe ? xfer_size_code_out : ~xfer_size_code_out;
    assign read_not_write_in = read_not_write_oe ? read_not_write_out : ~read_not_write_out;
    assign data_ack_n_in     = data_ack_n_oe ? data_ack_n_out : m_ack_n;
    sbi_bus_if u_sbi_bus_if (.clk, .rst_n, .clk_link, .reset_in_n, .reset_out_n,
        .bus_clock_out, .boot_width_strap, .boot_device_strap, .boot_cfg, .req_valid, .req,
        .req_ready, .rsp_valid, .rsp_rdata, .ext_owner, .ext_ack_req, .sys_addr_bus_in,
        .sys_addr_bus_out, .sys_addr_bus_oe, .sys_data_bus_in, .sys_data_bus_out,
        .sys_data_bus_oe, .addr_strobe_n_in, .addr_strobe_n_out, .addr_strobe_n_oe,
        .chip_select_n, .xfer_size_code_in, .xfer_size_code_out, .xfer_size_code_oe,
        .read_enable_n, .write_enable_n, .read_not_write_in, .read_not_write_out,
        .read_not_write_oe, .data_ack_n_in, .data_ack_n_out, .data_ack_n_oe,
        .bus_request_n, .bus_grant_n);
    sbi_mem_model u_sbi_mem_model (.clk, .rst_n, .wait_cyc, .addr(sys_addr_bus_out),
        .wdata(sys_data_bus_out), .rdata(m_rdata), .cs_n(chip_select_n),
        .re_n(read_enable_n), .we_n(write_enable_n), .ack_n(m_ack_n));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One transfer; pins seen at the strobe are kept in the s_ snapshot
    task automatic xfer(input logic rd, input logic [1:0] sz, input logic [2:0] cs,
        input logic [31:0] a, input logic [31:0] wd, input logic hs);
        logic taken, seen;
        taken = 1'b0;
        seen  = 1'b0;
        b     = 0;
        s_we  = 4'hF;
        @(posedge clk);
        #1;
        req = '{addr: a, wdata: wd, size: sz, rd: rd, cs: cs, be: 4'hF, handshake: hs};
        req_valid = 1'b1;
        for (int n = 0; n < 20 && !taken; n++) begin
            @(negedge clk);
            taken = req_ready === 1'b1;
            @(posedge clk);
            #1;
        end
        req_valid = 1'b0;
        `CHK(taken, 1'b1)
        for (int n = 0; n < 60 && !(seen && chip_select_n === 8'hFF); n++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) begin
                b++;
                q = rsp_rdata;
            end
            if (!seen && addr_strobe_n_out === 1'b0) begin
                seen = 1'b1;
                {s_addr, s_cs, s_size, s_rnw, s_oe} = {sys_addr_bus_out, chip_select_n,
                    xfer_size_code_out, read_not_write_out, sys_addr_bus_oe,
                    sys_data_bus_oe, addr_strobe_n_oe, xfer_size_code_oe};
            end
            if (write_enable_n !== 4'hF)
                s_we = write_enable_n;
        end
        `CHK(chip_select_n, 8'hFF)
        repeat (3) @(posedge clk);
    endtask
    task automatic t_boot();
        logic [1:0] lvl;
        lvl = 2'h0;
        `WAIT(reset_out_n === 1'b1)
        `CHK(boot_cfg, 2'h2)
        for (int n = 0; n < 8; n++) begin
            @(negedge clk);
            lvl[bus_clock_out] = 1'b1;
        end
        `CHK(lvl, 2'h3)
        @(posedge clk);
        #1;
        {boot_width_strap, boot_device_strap} = 2'h1;
        repeat (6) @(posedge clk);
        `CHK(boot_cfg, 2'h2)
        $display("test boot done");
    endtask
    task automatic t_write_read();
        wait_cyc = 2'h3;
        xfer(1'b0, sbi_pkg::SZ_WORD, 3'h2, 32'h0000_0040, 32'h1234_5678, 1'b1);
        `CHK({s_rnw, s_cs, s_we, s_addr}, {1'b0, 8'hFB, 4'h0, 32'h40})
        `CHK(s_oe, 4'hF)
        wait_cyc = 2'h0;
        xfer(1'b1, sbi_pkg::SZ_WORD, 3'h2, 32'h0000_0040, 32'h0, 1'b1);
        `CHK({s_rnw, q}, {1'b1, 32'h1234_5678})
        `CHK(s_oe, 4'hB)
        $display("test write read done");
    endtask
    task automatic t_sizes();
        logic [31:0] exp_q;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, i[1:0], i[2:0], 32'(i) << 4, 32'h0, 1'b0);
            `CHK({s_size, s_cs}, {i[1:0], ~(8'h01 << i)})
            `CHK(b, (i % 4 == 3) ? 4 : 1)
            // Last beat of a burst ends on word 15; word 0 holds the earlier write
            exp_q = (i % 4 == 3) ? 32'hA5A5_000F : 32'hA5A5_0000 + 32'(i % 4 * 4);
            if (i % 4 == 0)
                exp_q = 32'h1234_5678;
            `CHK(q, exp_q)
        end
        $display("test sizes done");
    endtask
    task automatic t_grant();
        logic hit;
        hit = 1'b0;
        @(posedge clk);
        #1;
        bus_request_n = 1'b0;
        `WAIT(bus_grant_n === 1'b0 && ext_owner === 1'b1)
        `CHK({bus_grant_n, ext_owner}, 2'h1)
        @(posedge clk);
        #1;
        {req_valid, ext_ack_req} = 2'h3;
        for (int n = 0; n < 6; n++) begin
            @(negedge clk);
            hit = hit | (req_ready === 1'b1);
        end
        `CHK({hit, data_ack_n_oe, data_ack_n_out}, 3'h2)
        @(posedge clk);
        #1;
        {req_valid, ext_ack_req, bus_request_n} = 3'h1;
        `WAIT(bus_grant_n === 1'b1 && ext_owner === 1'b0)
        `CHK({bus_grant_n, ext_owner}, 2'h2)
        $display("test grant done");
    endtask
    task automatic t_pin_reset();
        @(posedge clk);
        #1;
        reset_in_n = 1'b0;
        `WAIT(reset_out_n === 1'b0)
        `CHK({reset_out_n, chip_select_n}, 9'h0FF)
        repeat (10) @(posedge clk);
        #1;
        reset_in_n = 1'b1;
        `WAIT(reset_out_n === 1'b1)
        `CHK(boot_cfg, 2'h1)
        xfer(1'b1, sbi_pkg::SZ_HALF, 3'h5, 32'h0000_0004, 32'h0, 1'b0);
        `CHK(b, 1)
        $display("test pin reset done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        `CHK(reset_out_n, 1'b0)
        rst_n = 1'b1;
        t_boot();
        t_write_read();
        t_sizes();
        t_grant();
        t_pin_reset();
        stop_test();
    end
endmodule

// File: src/sbi_bus_if.sv
// Purpose: Device side of the external system bus, at its pins.
// Assumes: Link logic runs on clk_link; the bus clock out is clk_link/2.
// Notes:   Two-way pins are split into in, out and output enable.
//
// Operation
// - Size code: 00 byte,01 half,10 word,11 burst
// - 32-bit address bus driven by current master
// - 32-bit bidirectional data path
// - Master drives address strobe low at start
// - Eight active-low chip selects
// - Read enable low throughout read access
// - Four write enables low during writes
// - Direction line high read, low write
// - Device drives acknowledge toward external master
// - Grant driven low when bus released
// - Boot width strap sampled at reset release
// - Boot select strap picks chip select 0/1 (code only latches it into boot_cfg.boot_cs0)
// - Held in reset while reset input low
// - Reset output low while in reset
// - Eight bus clocks before reset output rises
// - Device outputs the system bus clock
`timescale 1ns/10ps
module sbi_bus_if (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_link,
    input  wire logic              reset_in_n,
    output logic                   reset_out_n,
    output logic                   bus_clock_out,
    input  wire logic              boot_width_strap,
    input  wire logic              boot_device_strap,
    output sbi_pkg::sbi_boot_t     boot_cfg,
    input  wire logic              req_valid,
    input  wire sbi_pkg::sbi_req_t req,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [31:0]            rsp_rdata,
    output logic                   ext_owner,
    input  wire logic              ext_ack_req,
    input  wire logic [31:0]       sys_addr_bus_in,
    output logic [31:0]            sys_addr_bus_out,
    output logic                   sys_addr_bus_oe,
    input  wire logic [31:0]       sys_data_bus_in,
    output logic [31:0]            sys_data_bus_out,
    output logic                   sys_data_bus_oe,
    input  wire logic              addr_strobe_n_in,
    output logic                   addr_strobe_n_out,
    output logic                   addr_strobe_n_oe,
    output logic [7:0]             chip_select_n,
    input  wire logic [1:0]        xfer_size_code_in,
    output logic [1:0]             xfer_size_code_out,
    output logic                   xfer_size_code_oe,
    output logic                   read_enable_n,
    output logic [3:0]             write_enable_n,
    input  wire logic              read_not_write_in,
    output logic                   read_not_write_out,
    output logic                   read_not_write_oe,
    input  wire logic              data_ack_n_in,
    output logic                   data_ack_n_out,
    output logic                   data_ack_n_oe,
    input  wire logic              bus_request_n,
    output logic                   bus_grant_n
);

    // --------------------------------------------------------------
    // Reset pin filter and internal reset
    // --------------------------------------------------------------
    logic [2:0] rin_sync;
    logic       rin_level;
    logic       in_reset;
    assign in_reset = !rst_n || !rin_level;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rin_sync  <= 3'h0;
            rin_level <= 1'b0;
        end else begin
            rin_sync <= {rin_sync[1:0], reset_in_n};
            if (rin_sync[1] == rin_sync[2]) begin
                rin_level <= rin_sync[2];
            end
        end
    end

    // Core-side reset request carried to the link domain as a level
    logic core_rst_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_n <= 1'b0;
        end else begin
            core_rst_n <= !in_reset;
        end
    end

    // --------------------------------------------------------------
    // Link domain: reset sequencing and bus clock
    // --------------------------------------------------------------
    // Three stages as for any crossing; the level counts once the last two agree
    logic [2:0] lrst_sync;
    logic       lrst_ok;
    logic       bclk;
    logic [3:0] rcnt;
    logic       rout;

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            lrst_sync <= 3'h0;
            lrst_ok   <= 1'b0;
            bclk      <= 1'b0;
            rcnt      <= sbi_pkg::RST_CNT_INIT;
            rout      <= 1'b0;
        end else begin
            lrst_sync <= {lrst_sync[1:0], core_rst_n};
            bclk      <= !bclk;
            if (lrst_sync[1] == lrst_sync[2]) begin
                lrst_ok <= lrst_sync[2];
            end
            if (!lrst_ok) begin
                rcnt <= sbi_pkg::RST_CNT_INIT;
                rout <= 1'b0;
            end else if (bclk && rcnt != 4'(sbi_pkg::RST_CLK_CYCLES)) begin
                rcnt <= rcnt + 4'h1;
            end else if (rcnt == 4'(sbi_pkg::RST_CLK_CYCLES)) begin
                rout <= 1'b1;
            end
        end
    end
    assign bus_clock_out = bclk;
    assign reset_out_n   = rout;

    // Released reset returns to the core domain through three stages
    logic [2:0] rel_sync;
    logic       run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_sync <= 3'h0;
            run      <= 1'b0;
        end else begin
            rel_sync <= {rel_sync[1:0], rout};
            if (in_reset) begin
                run <= 1'b0;
            end else if (rel_sync[1] == rel_sync[2]) begin
                run <= rel_sync[2];
            end
        end
    end

    // --------------------------------------------------------------
    // Boot straps, caught once at reset release
    // --------------------------------------------------------------
    logic [2:0] bw_sync;
    logic [2:0] bs_sync;
    logic       straps_taken;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bw_sync      <= 3'h0;
            bs_sync      <= 3'h0;
            straps_taken <= 1'b0;
            boot_cfg     <= '0;
        end else begin
            bw_sync <= {bw_sync[1:0], boot_width_strap};
            bs_sync <= {bs_sync[1:0], boot_device_strap};
            if (in_reset) begin
                straps_taken <= 1'b0;
            end else if (!straps_taken) begin
                straps_taken       <= 1'b1;
                boot_cfg.boot_wide <= bw_sync[2];
                boot_cfg.boot_cs0  <= bs_sync[2];
            end
        end
    end

    // --------------------------------------------------------------
    // Bus master sequencer (core clock; the pins are sampled by bench
    // on the falling edge of clk; bus_clock_out is slower than clk)
    // --------------------------------------------------------------
    logic [2:0] ack_sync;
    logic [2:0] breq_sync;
    // Held levels: a one-cycle glitch on either pin never reaches the sequencer
    logic       ack_seen;
    logic       breq_seen;

    sbi_pkg::sbi_state_t state;
    sbi_pkg::sbi_state_t next_state;
    sbi_pkg::sbi_req_t   cur;
    logic [3:0]          beats;

    wire req_take  = run && req_valid && state == sbi_pkg::SBI_IDLE && !breq_seen;
    wire ack_ok    = !cur.handshake || ack_seen;
    wire last_beat = cur.size != sbi_pkg::SZ_BURST || beats == sbi_pkg::BURST_BEATS - 4'h1;
    wire owned     = state == sbi_pkg::SBI_ADDR || state == sbi_pkg::SBI_DATA;
    // Next beat's address goes out with the beat, so each beat reads its own word
    wire [31:0] pin_addr = (state == sbi_pkg::SBI_DATA && ack_ok && !last_beat) ?
        cur.addr + 32'h4 : cur.addr;

    always_comb begin
        next_state = state;
        case (state)
            sbi_pkg::SBI_IDLE: begin
                if (req_take) begin
                    next_state = sbi_pkg::SBI_ADDR;
                end else if (run && breq_seen) begin
                    next_state = sbi_pkg::SBI_GRANT;
                end
            end
            sbi_pkg::SBI_ADDR: next_state = sbi_pkg::SBI_DATA;
            sbi_pkg::SBI_DATA: begin
                if (ack_ok && last_beat) begin
                    next_state = sbi_pkg::SBI_DONE;
                end
            end
            sbi_pkg::SBI_DONE: next_state = sbi_pkg::SBI_IDLE;
            sbi_pkg::SBI_GRANT: begin
                if (!breq_seen) begin
                    next_state = sbi_pkg::SBI_IDLE;
                end
            end
            default: next_state = sbi_pkg::SBI_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync  <= 3'h7;
            breq_sync <= 3'h7;
            ack_seen  <= 1'b0;
            breq_seen <= 1'b0;
            req_ready <= 1'b0;
            state     <= sbi_pkg::SBI_IDLE;
            cur       <= '0;
            beats     <= 4'h0;
            rsp_rdata <= 32'h0;
            rsp_valid <= 1'b0;
        end else begin
            ack_sync  <= {ack_sync[1:0], data_ack_n_in};
            breq_sync <= {breq_sync[1:0], bus_request_n};
            if (ack_sync[1] == ack_sync[2]) begin
                ack_seen <= !ack_sync[2];
            end
            if (breq_sync[1] == breq_sync[2]) begin
                breq_seen <= !breq_sync[2];
            end
            // Registered: high in the cycle after the take
            req_ready <= req_take;
            state     <= in_reset ? sbi_pkg::SBI_IDLE : next_state;
            rsp_valid <= state == sbi_pkg::SBI_DATA && ack_ok && cur.rd;
            if (req_take) begin
                cur   <= req;
                beats <= 4'h0;
            end else if (state == sbi_pkg::SBI_DATA && ack_ok) begin
                beats    <= beats + 4'h1;
                cur.addr <= cur.addr + 32'h4;
            end
            if (state == sbi_pkg::SBI_DATA && ack_ok) begin
                rsp_rdata <= sys_data_bus_in;
            end
        end
    end

    // --------------------------------------------------------------
    // Pin drivers, all registered
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_addr_bus_out   <= 32'h0;
            sys_addr_bus_oe    <= 1'b0;
            sys_data_bus_out   <= 32'h0;
            sys_data_bus_oe    <= 1'b0;
            addr_strobe_n_out  <= 1'b1;
            addr_strobe_n_oe   <= 1'b0;
            chip_select_n      <= sbi_pkg::CS_IDLE;
            xfer_size_code_out <= sbi_pkg::SZ_BYTE;
            xfer_size_code_oe  <= 1'b0;
            read_enable_n      <= 1'b1;
            write_enable_n     <= sbi_pkg::WE_IDLE;
            read_not_write_out <= 1'b1;
            read_not_write_oe  <= 1'b0;
            data_ack_n_out     <= 1'b1;
            data_ack_n_oe      <= 1'b0;
            bus_grant_n        <= 1'b1;
            ext_owner          <= 1'b0;
        end else begin
            sys_addr_bus_out   <= pin_addr;
            sys_addr_bus_oe    <= owned;
            sys_data_bus_out   <= cur.wdata;
            sys_data_bus_oe    <= owned && !cur.rd;
            addr_strobe_n_out  <= !(state == sbi_pkg::SBI_ADDR);
            addr_strobe_n_oe   <= owned;
            chip_select_n      <= owned ? ~(8'h1 << cur.cs) : sbi_pkg::CS_IDLE;
            xfer_size_code_out <= cur.size;
            xfer_size_code_oe  <= owned;
            read_enable_n      <= !(owned && cur.rd);
            write_enable_n     <= (owned && !cur.rd) ? ~cur.be : sbi_pkg::WE_IDLE;
            read_not_write_out <= cur.rd;
            read_not_write_oe  <= owned;
            data_ack_n_out     <= !(state == sbi_pkg::SBI_GRANT && ext_ack_req);
            data_ack_n_oe      <= state == sbi_pkg::SBI_GRANT;
            bus_grant_n        <= !(state == sbi_pkg::SBI_GRANT);
            ext_owner          <= state == sbi_pkg::SBI_GRANT;
        end
    end

endmodule

// File: src/sbi_pkg.sv
// Purpose: Shared constants and types for the system bus pin interface.
// Assumes: Core clock 100 MHz; bus clock output derived by a divider.
// Notes:   Package is referenced by scoped names only.
package sbi_pkg;

    // --------------------------------------------------------------
    // Transfer size codes
    // --------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE  = 2'h0;
    localparam logic [1:0] SZ_HALF  = 2'h1;
    localparam logic [1:0] SZ_WORD  = 2'h2;
    localparam logic [1:0] SZ_BURST = 2'h3;

    // --------------------------------------------------------------
    // Counts and reset values
    // --------------------------------------------------------------
    localparam int          RST_CLK_CYCLES = 8;
    localparam logic [3:0]  RST_CNT_INIT   = 4'h0;
    localparam logic [3:0]  BURST_BEATS    = 4'h4;
    localparam logic [7:0]  CS_IDLE        = 8'hFF;
    localparam logic [3:0]  WE_IDLE        = 4'hF;
    localparam int          BOOT_CS_HI     = 0;
    localparam int          BOOT_CS_LO     = 1;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        SBI_IDLE  = 3'h0,
        SBI_ADDR  = 3'h1,
        SBI_DATA  = 3'h3,
        SBI_DONE  = 3'h2,
        SBI_GRANT = 3'h6
    } sbi_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0]  size;
        logic        rd;
        logic [2:0]  cs;
        logic [3:0]  be;
        logic        handshake;
    } sbi_req_t;

    typedef struct packed {
        logic        boot_wide;
        logic        boot_cs0;
    } sbi_boot_t;

endpackage
